/* hdl/clock_gate_pkg.sv */
// Constants for the peripheral clock gate bank
package clock_gate_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // Register offsets (byte addresses, one word each)
    localparam logic [3:0] OFS_GATE_CTRL_A = 4'h0;
    localparam logic [3:0] OFS_GATE_CTRL_B = 4'h4;
    localparam logic [3:0] OFS_LP_STATUS   = 4'h8;

    // Field positions, first gating register
    localparam int unsigned BIT_TIMER_ACC  = 0;
    localparam int unsigned BIT_PORT_FIRST = 9;
    localparam int unsigned BIT_PORT_SEC   = 10;

    // Field positions, second gating register
    localparam int unsigned BIT_FLASH      = 0;
    localparam int unsigned BIT_TPM_FIRST  = 24;
    localparam int unsigned BIT_TPM_SEC    = 25;
    localparam int unsigned BIT_CONVERTER  = 27;

    // Status register fields
    localparam int unsigned BIT_LP_BLOCKED = 0;
    localparam int unsigned BIT_LP_GRANTED = 1;

    // Writable masks and constant reserved patterns
    localparam logic [31:0] WMASK_A = 32'h0000_0601;
    localparam logic [31:0] FIXED_A = 32'h0000_0180;
    localparam logic [31:0] WMASK_B = 32'h0b00_0001;
    localparam logic [31:0] FIXED_B = 32'h0000_0000;

    // Reset values of the writable bits
    localparam logic [31:0] RESET_A = 32'h0000_0000;
    localparam logic [31:0] RESET_B = 32'h0000_0001;

endpackage

/* hdl/gate_reg_field.sv */
// One masked gating register with constant reserved bits
`timescale 1ns/1ps
module gate_reg_field #(
    parameter logic [31:0] WMASK = 32'h0,
    parameter logic [31:0] FIXED = 32'h0,
    parameter logic [31:0] RESET = 32'h0
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Write port
    input  wire logic        wr_in,
    input  wire logic [31:0] wdata_in,
    // Register view
    output logic      [31:0] value_out
);
    typedef struct packed
    {
        logic [31:0] bits;
    } state_s;

    state_s state;
    state_s next_state;

    always_comb
    begin
        next_state = state;
        if (wr_in)
        begin
            next_state.bits = wdata_in & WMASK;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state.bits <= RESET & WMASK;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Reserved bits come from constants, never from storage
    assign value_out = (state.bits & WMASK) | (FIXED & ~WMASK);
endmodule

/* hdl/lp_entry_guard.sv */
// Low-power entry gate: blocked while the flash clock is stopped
`timescale 1ns/1ps
module lp_entry_guard (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    // Control
    input  wire logic flash_gate_in,
    input  wire logic lp_request_in,
    // Result
    output logic      lp_grant_out,
    output logic      lp_blocked_out
);
    typedef struct packed
    {
        logic grant;
        logic blocked;
    } state_s;

    state_s state;
    state_s next_state;

    always_comb
    begin
        next_state.grant   = lp_request_in & flash_gate_in;
        next_state.blocked = lp_request_in & ~flash_gate_in;
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign lp_grant_out   = state.grant;
    assign lp_blocked_out = state.blocked;
endmodule

/* hdl/peripheral_clock_gate_bank.sv */
// Peripheral clock gate bank: two gating registers and their gate outputs
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - Gate bit 0 stops clock, 1 runs.
// - Register A bit 10 gates second port.
// - Register A bit 9 gates first port.
// - Register A bit 0 enables timer access.
// - Register B bit 27 gates converter.
// - Register B bit 25 gates second timer.
// - Register B bit 24 gates first timer.
// - Register B bit 0 gates flash.
// - Flash reads continue while flash gated.
// - Flash gated blocks low-power entry.
// - Register A bits 8..7 read one.
// - Other reserved bits read zero, ignore writes.
module peripheral_clock_gate_bank (
    // Clock and reset
    input  wire logic                               clock_in,
    input  wire logic                               rst_n_in,
    // Register port
    input  wire logic [clock_gate_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [clock_gate_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                               wr_in,
    input  wire logic                               rd_in,
    output logic      [clock_gate_pkg::DATA_W-1:0]  rdata_out,
    // Low-power handshake
    input  wire logic                               lp_request_in,
    output logic                                    lp_grant_out,
    // Flash read path
    input  wire logic                               flash_rd_in,
    output logic                                    flash_rd_en_out,
    // Gate outputs
    output logic                                    port_second_gate_out,
    output logic                                    port_first_gate_out,
    output logic                                    low_power_timer_access_en_out,
    output logic                                    converter_gate_out,
    output logic                                    timer_pwm_second_gate_out,
    output logic                                    timer_pwm_first_gate_out,
    output logic                                    flash_gate_out
);
    import clock_gate_pkg::*;

    // ********************************
    // Register decode
    // ********************************
    logic        wr_a;
    logic        wr_b;
    logic [31:0] reg_a;
    logic [31:0] reg_b;
    logic        lp_blocked;
    logic        lp_grant;

    assign wr_a = wr_in && (addr_in == OFS_GATE_CTRL_A);
    assign wr_b = wr_in && (addr_in == OFS_GATE_CTRL_B);

    // Reserved bits are constant; writes only land on gate bits
    gate_reg_field #(
        .WMASK (WMASK_A),
        .FIXED (FIXED_A),
        .RESET (RESET_A)
    ) u_reg_a (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .wr_in     (wr_a),
        .wdata_in  (wdata_in),
        .value_out (reg_a)
    );

    gate_reg_field #(
        .WMASK (WMASK_B),
        .FIXED (FIXED_B),
        .RESET (RESET_B)
    ) u_reg_b (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n_in),
        .wr_in     (wr_b),
        .wdata_in  (wdata_in),
        .value_out (reg_b)
    );

    // ********************************
    // Low-power entry guard
    // ********************************
    lp_entry_guard u_guard (
        .clock_in       (clock_in),
        .rst_n_in       (rst_n_in),
        .flash_gate_in  (reg_b[BIT_FLASH]),
        .lp_request_in  (lp_request_in),
        .lp_grant_out   (lp_grant),
        .lp_blocked_out (lp_blocked)
    );

    // ********************************
    // Output state
    // ********************************
    typedef struct packed
    {
        logic [31:0] rdata;
        logic        port_second;
        logic        port_first;
        logic        timer_access;
        logic        converter;
        logic        tpm_second;
        logic        tpm_first;
        logic        flash;
        logic        flash_rd;
    } state_s;

    state_s state;
    state_s next_state;

    // Gate flop loads in the edge that writes its register bit
    function automatic logic gate_next(
        input logic        wr,
        input logic [31:0] data,
        input logic [31:0] held,
        input int unsigned pos
    );
        return wr ? data[pos] : held[pos];
    endfunction

    always_comb
    begin
        next_state = state;
        // Read data stands only in the cycle after the strobe
        next_state.rdata = '0;
        if (rd_in)
        begin
            unique case (addr_in)
                OFS_GATE_CTRL_A:
                begin
                    next_state.rdata = reg_a;
                end
                OFS_GATE_CTRL_B:
                begin
                    next_state.rdata = reg_b;
                end
                OFS_LP_STATUS:
                begin
                    next_state.rdata[BIT_LP_BLOCKED] = lp_blocked;
                    next_state.rdata[BIT_LP_GRANTED] = lp_grant;
                end
                default:
                begin
                    next_state.rdata = '0;
                end
            endcase
        end
        // Gate flops load with their register bit, 1 = clock runs
        next_state.port_second  = gate_next(wr_a, wdata_in, reg_a, BIT_PORT_SEC);
        next_state.port_first   = gate_next(wr_a, wdata_in, reg_a, BIT_PORT_FIRST);
        next_state.timer_access = gate_next(wr_a, wdata_in, reg_a, BIT_TIMER_ACC);
        next_state.converter    = gate_next(wr_b, wdata_in, reg_b, BIT_CONVERTER);
        next_state.tpm_second   = gate_next(wr_b, wdata_in, reg_b, BIT_TPM_SEC);
        next_state.tpm_first    = gate_next(wr_b, wdata_in, reg_b, BIT_TPM_FIRST);
        next_state.flash        = gate_next(wr_b, wdata_in, reg_b, BIT_FLASH);
        // Reads never depend on the flash gate
        next_state.flash_rd     = flash_rd_in;
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state              <= '0;
            state.port_second  <= RESET_A[BIT_PORT_SEC];
            state.port_first   <= RESET_A[BIT_PORT_FIRST];
            state.timer_access <= RESET_A[BIT_TIMER_ACC];
            state.converter    <= RESET_B[BIT_CONVERTER];
            state.tpm_second   <= RESET_B[BIT_TPM_SEC];
            state.tpm_first    <= RESET_B[BIT_TPM_FIRST];
            state.flash        <= RESET_B[BIT_FLASH];
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rdata_out                     = state.rdata;
    assign port_second_gate_out          = state.port_second;
    assign port_first_gate_out           = state.port_first;
    assign low_power_timer_access_en_out = state.timer_access;
    assign converter_gate_out            = state.converter;
    assign timer_pwm_second_gate_out     = state.tpm_second;
    assign timer_pwm_first_gate_out      = state.tpm_first;
    assign flash_gate_out                = state.flash;
    assign flash_rd_en_out               = state.flash_rd;
    assign lp_grant_out                  = lp_grant;

    // ********************************
    // Checks
    // ********************************
    sequence s_write_a_bit10(logic v);
        wr_in && addr_in == OFS_GATE_CTRL_A && wdata_in[10] == v;
    endsequence

    property p_port_second;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_write_a_bit10(1'b1) |=> port_second_gate_out;
    endproperty
    a_port_second: assert property (p_port_second) else $error("port two gate");

    property p_port_first;
        @(posedge clock_in) disable iff (!rst_n_in)
        (wr_in && addr_in == OFS_GATE_CTRL_A)
        |=> port_first_gate_out == $past(wdata_in[9]);
    endproperty
    a_port_first: assert property (p_port_first) else $error("port one gate");

    property p_timer_access;
        @(posedge clock_in) disable iff (!rst_n_in)
        (wr_in && addr_in == OFS_GATE_CTRL_A)
        |=> low_power_timer_access_en_out == $past(wdata_in[0]);
    endproperty
    a_timer_access: assert property (p_timer_access) else $error("timer access");

    property p_converter;
        @(posedge clock_in) disable iff (!rst_n_in)
        (wr_in && addr_in == OFS_GATE_CTRL_B)
        |=> converter_gate_out == $past(wdata_in[27]);
    endproperty
    a_converter: assert property (p_converter) else $error("converter gate");

    property p_tpm;
        @(posedge clock_in) disable iff (!rst_n_in)
        (wr_in && addr_in == OFS_GATE_CTRL_B)
        |=> {timer_pwm_second_gate_out, timer_pwm_first_gate_out}
                == $past(wdata_in[25:24]);
    endproperty
    a_tpm: assert property (p_tpm) else $error("timer gates");

    property p_flash;
        @(posedge clock_in) disable iff (!rst_n_in)
        (wr_in && addr_in == OFS_GATE_CTRL_B)
        |=> flash_gate_out == $past(wdata_in[0]);
    endproperty
    a_flash: assert property (p_flash) else $error("flash gate");

    property p_flash_read;
        @(posedge clock_in) disable iff (!rst_n_in)
        flash_rd_in |=> flash_rd_en_out;
    endproperty
    a_flash_read: assert property (p_flash_read) else $error("flash read lost");

    property p_lp_block;
        @(posedge clock_in) disable iff (!rst_n_in)
        (!reg_b[0] && !$past(reg_b[0])) |-> !lp_grant_out;
    endproperty
    a_lp_block: assert property (p_lp_block) else $error("lp entry granted");

    property p_reserved_a;
        @(posedge clock_in) disable iff (!rst_n_in)
        (rd_in && addr_in == OFS_GATE_CTRL_A)
        |=> rdata_out[8:7] == 2'h3 && rdata_out[31:11] == '0 && rdata_out[6:1] == '0;
    endproperty
    a_reserved_a: assert property (p_reserved_a) else $error("reserved a");

    property p_reserved_b;
        @(posedge clock_in) disable iff (!rst_n_in)
        (rd_in && addr_in == OFS_GATE_CTRL_B)
        |=> (rdata_out & ~WMASK_B) == '0;
    endproperty
    a_reserved_b: assert property (p_reserved_b) else $error("reserved b");

    property p_port_two_off;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_write_a_bit10(1'b0) |=> !port_second_gate_out;
    endproperty
    a_port_two_off: assert property (p_port_two_off) else $error("port two stop");

    // Reserved bits must survive any write, whatever the data
    sequence s_write_a;
        wr_in && addr_in == OFS_GATE_CTRL_A;
    endsequence

    sequence s_write_b;
        wr_in && addr_in == OFS_GATE_CTRL_B;
    endsequence

    property p_hold_res_a;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_write_a |=> (reg_a & ~WMASK_A) == FIXED_A;
    endproperty
    a_hold_res_a: assert property (p_hold_res_a) else $error("reserved a hit");

    property p_hold_res_b;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_write_b |=> (reg_b & ~WMASK_B) == FIXED_B;
    endproperty
    a_hold_res_b: assert property (p_hold_res_b) else $error("reserved b hit");

    property p_unmapped;
        @(posedge clock_in) disable iff (!rst_n_in)
        (rd_in && addr_in != OFS_GATE_CTRL_A && addr_in != OFS_GATE_CTRL_B
            && addr_in != OFS_LP_STATUS)
        |=> rdata_out == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");

    property p_status_read;
        @(posedge clock_in) disable iff (!rst_n_in)
        (rd_in && addr_in == OFS_LP_STATUS)
        |=> rdata_out[BIT_LP_GRANTED] == $past(lp_grant_out) && rdata_out[31:2] == '0;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read");

    // Grant follows the stored flash bit, never a stale request
    property p_grant_run;
        @(posedge clock_in) disable iff (!rst_n_in)
        (lp_request_in && reg_b[BIT_FLASH]) |=> lp_grant_out;
    endproperty
    a_grant_run: assert property (p_grant_run) else $error("lp entry refused");

    property p_grant_idle;
        @(posedge clock_in) disable iff (!rst_n_in)
        !lp_request_in |=> !lp_grant_out;
    endproperty
    a_grant_idle: assert property (p_grant_idle) else $error("grant unasked");

    property p_flash_follow;
        @(posedge clock_in) disable iff (!rst_n_in)
        !flash_gate_out |=> flash_rd_en_out == $past(flash_rd_in);
    endproperty
    a_flash_follow: assert property (p_flash_follow) else $error("flash read gated");

    property p_hold_a;
        @(posedge clock_in) disable iff (!rst_n_in)
        !(wr_in && addr_in == OFS_GATE_CTRL_A)
        |=> $stable({port_second_gate_out, port_first_gate_out,
                     low_power_timer_access_en_out});
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("gate a moved");

    property p_hold_b;
        @(posedge clock_in) disable iff (!rst_n_in)
        !(wr_in && addr_in == OFS_GATE_CTRL_B)
        |=> $stable({converter_gate_out, timer_pwm_second_gate_out,
                     timer_pwm_first_gate_out, flash_gate_out});
    endproperty
    a_hold_b: assert property (p_hold_b) else $error("gate b moved");

    property p_flash_mirror;
        @(posedge clock_in) disable iff (!rst_n_in)
        flash_gate_out == reg_b[BIT_FLASH];
    endproperty
    a_flash_mirror: assert property (p_flash_mirror) else $error("flash gate stale");
endmodule

/* testbench/tb.sv */
// Self-checking testbench for the peripheral clock gate bank
`timescale 1ns/1ps
module tb;
    import clock_gate_pkg::*;

    // ****************************************
    // Signals and design instance
    // ****************************************
    logic        clock_in;
    logic        rst_n_in;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        lp_req;
    logic        lp_grant;
    logic        flash_rd;
    logic        flash_rd_en;
    wire  [6:0]  gates;
    logic [31:0] seen;
    int          n_errors;
    int          cmp_count;
    int          cycles;
    int          ofs_tab [7] = '{0, 0, 0, 4, 4, 4, 4};
    int          bit_tab [7] = '{10, 9, 0, 27, 25, 24, 0};

    peripheral_clock_gate_bank DUT (
        .clock_in                      (clock_in),
        .rst_n_in                      (rst_n_in),
        .addr_in                       (addr),
        .wdata_in                      (wdata),
        .wr_in                         (wr),
        .rd_in                         (rd),
        .rdata_out                     (rdata),
        .lp_request_in                 (lp_req),
        .lp_grant_out                  (lp_grant),
        .flash_rd_in                   (flash_rd),
        .flash_rd_en_out               (flash_rd_en),
        .port_second_gate_out          (gates[6]),
        .port_first_gate_out           (gates[5]),
        .low_power_timer_access_en_out (gates[4]),
        .converter_gate_out            (gates[3]),
        .timer_pwm_second_gate_out     (gates[2]),
        .timer_pwm_first_gate_out      (gates[1]),
        .flash_gate_out                (gates[0])
    );

    always #2.5 clock_in = ~clock_in;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Strobe lowered, then one idle edge so the next call never reassigns it
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clock_in);
    endtask

    // One spare edge, then a mid-cycle look at the outputs
    task automatic settle();
        @(posedge clock_in);
        #1;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            stop_test();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        clock_in = 1'b0;
        rst_n_in = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        lp_req = 1'b0;
        flash_rd = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);

        reg_read(OFS_GATE_CTRL_A, seen);
        chk("ctrl_a reset", seen, 32'h0000_0180);
        reg_read(OFS_GATE_CTRL_B, seen);
        chk("ctrl_b reset", seen, 32'h0000_0001);
        chk("gates reset", {25'h0, gates}, 32'h0000_0001);
        reg_read(4'hc, seen);
        chk("unmapped read", seen, 32'h0000_0000);
        $display("Test reset values done");

        reg_write(OFS_GATE_CTRL_A, 32'hffff_ffff);
        reg_write(OFS_GATE_CTRL_B, 32'hffff_ffff);
        reg_read(OFS_GATE_CTRL_A, seen);
        chk("ctrl_a ones", seen, 32'h0000_0781);
        reg_read(OFS_GATE_CTRL_B, seen);
        chk("ctrl_b ones", seen, 32'h0b00_0001);
        chk("gates ones", {25'h0, gates}, 32'h0000_007f);
        reg_write(4'hc, 32'h0000_0000);
        reg_write(OFS_LP_STATUS, 32'h0000_0000);
        reg_read(OFS_GATE_CTRL_A, seen);
        chk("ctrl_a after stray", seen, 32'h0000_0781);
        $display("Test reserved bits done");

        for (int i = 0; i < 7; i++)
        begin
            reg_write(OFS_GATE_CTRL_A, 32'h0000_0000);
            reg_write(OFS_GATE_CTRL_B, 32'h0000_0000);
            reg_write(ofs_tab[i][3:0], 32'h1 << bit_tab[i]);
            settle();
            chk("one gate", {25'h0, gates}, 32'h1 << (6 - i));
            reg_read(ofs_tab[i][3:0], seen);
            chk("one bit readback", seen,
                (32'h1 << bit_tab[i]) | (i < 3 ? 32'h0000_0180 : 32'h0));
        end
        reg_write(OFS_GATE_CTRL_A, 32'h0000_0000);
        reg_write(OFS_GATE_CTRL_B, 32'h0000_0000);
        settle();
        chk("all stopped", {25'h0, gates}, 32'h0000_0000);
        $display("Test gate mapping done");

        lp_req <= 1'b1;
        flash_rd <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        chk("grant flash stopped", {31'h0, lp_grant}, 32'h0);
        chk("flash read stopped", {31'h0, flash_rd_en}, 32'h1);
        reg_read(OFS_LP_STATUS, seen);
        chk("status blocked", seen & 32'h3, 32'h1);
        reg_write(OFS_GATE_CTRL_B, 32'h0000_0001);
        repeat (3) @(posedge clock_in);
        #1;
        chk("grant flash running", {31'h0, lp_grant}, 32'h1);
        chk("flash read running", {31'h0, flash_rd_en}, 32'h1);
        reg_read(OFS_LP_STATUS, seen);
        chk("status granted", seen & 32'h3, 32'h2);
        lp_req <= 1'b0;
        flash_rd <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        chk("grant released", {31'h0, lp_grant}, 32'h0);
        chk("flash read released", {31'h0, flash_rd_en}, 32'h0);
        $display("Test low power and flash done");

        addr <= OFS_GATE_CTRL_A;
        wdata <= 32'hffff_ffff;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
        #1;
        chk("gates next cycle", {25'h0, gates}, 32'h0000_0071);
        rst_n_in <= 1'b0;
        #1;
        chk("gates in reset", {25'h0, gates}, 32'h0000_0001);
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        reg_read(OFS_GATE_CTRL_A, seen);
        chk("ctrl_a after reset", seen, 32'h0000_0180);
        $display("Test mid-run reset done");

        stop_test();
    end
endmodule
